//--- inc/epcc_pkg.sv
// Purpose: constants for the enclave page create/block checker
// Assumes: 64-bit operand addresses, 4 KiB pages
// Notes: register map sits on apb, word aligned
// Overview of operation
// - block leaf done: zero flag set when control structure busy or invalid
// - block leaf done: carry flag set when page already blocked or unblockable (code sets it only for an already blocked slot)
// - block leaf done without fault: clears parity, aux carry, overflow and sign flags
// - protected mode: operand beyond data segment limit gives gp fault 0
// - any misaligned memory operand gives gp fault 0
// - create leaf: page cache resource in use gives gp fault 0 (block leaf sets zero flag)
// - operand access fault or non page-cache page gives page fault
// - 64-bit mode: non-canonical operand address gives gp fault 0
// - create leaf selected by leaf select 00h, valid in both modes
// - create copies control structure into target page and marks valid
// - create checks unused fields; layout hidden from software
// - create faults if descriptor control field or other unused field nonzero
// - create faults if target in use, already valid, or outside cache
// - save area frame smaller than needed space gives gp fault 0
// - descriptor and sources read non-enclave; target written enclave
// - create on control page excluded from conflicting concurrent leaves
// - create faults unless enclave size is a power of two
// - create faults unless extended feature mask and 03h equals 03h
package epcc_pkg;
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_LEAF      = 8'h04;
  localparam logic [7:0]  ADDR_PARAM_LO  = 8'h08;
  localparam logic [7:0]  ADDR_PARAM_HI  = 8'h0c;
  localparam logic [7:0]  ADDR_TARG_LO   = 8'h10;
  localparam logic [7:0]  ADDR_TARG_HI   = 8'h14;
  localparam logic [7:0]  ADDR_SRC_LO    = 8'h18;
  localparam logic [7:0]  ADDR_SINFO_LO  = 8'h1c;
  localparam logic [7:0]  ADDR_SIZE_LO   = 8'h20;
  localparam logic [7:0]  ADDR_SIZE_HI   = 8'h24;
  localparam logic [7:0]  ADDR_BASE_LO   = 8'h28;
  localparam logic [7:0]  ADDR_BASE_HI   = 8'h2c;
  localparam logic [7:0]  ADDR_ATTR      = 8'h30;
  localparam logic [7:0]  ADDR_SSA       = 8'h34;
  localparam logic [7:0]  ADDR_ENV       = 8'h38;
  localparam logic [7:0]  ADDR_STATUS    = 8'h3c;
  localparam logic [7:0]  ADDR_NEED      = 8'h40;
  localparam logic [7:0]  LEAF_CREATE    = 8'h00;
  localparam logic [7:0]  LEAF_BLOCK     = 8'h09;
  localparam logic [1:0]  EXTENDED_FEATURE_MASK_LOW       = 2'h3;
  localparam logic [63:0] MIN_SIZE       = 64'h0000_0000_0000_2000;
  localparam int          PAGE_BITS      = 12;
  localparam int          DESC_BITS      = 5;
  localparam int          SINFO_BITS     = 6;
  localparam int          VA_BITS        = 48;
  // ctrl fields
  localparam int          CTRL_GO        = 0;
  // env fields (loose inputs captured from software)
  localparam int          ENV_M64        = 0;
  localparam int          ENV_DESC_ZERO  = 1;
  localparam int          ENV_SINFO_OK   = 2;
  localparam int          ENV_RSV_ZERO   = 3;
  localparam int          ENV_ACC_FAULT  = 4;
  localparam int          ENV_LIMIT      = 5;
  // fault codes
  typedef enum logic [1:0] {
    FLT_NONE = 2'b00,
    FLT_GP   = 2'b01,
    FLT_PF   = 2'b10
  } epcc_fault_type;
  localparam logic [31:0] GP_CODE        = 32'h0000_0000;
endpackage : epcc_pkg

//--- core/epcc_slot.sv
// Purpose: per-slot page-cache map state for target pages
// Assumes: slot index from target address page number
// Notes: valid and blocked bits in flip-flops
`timescale 1ns/10ps
module epcc_slot #(
  parameter int SLOTS = 16
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic [$clog2(SLOTS)-1:0] idx,
  input  wire logic                     set_valid,
  input  wire logic                     set_block,
  output logic                          valid,
  output logic                          blocked
);
  import epcc_pkg::*;
  logic [SLOTS-1:0] valid_ff;
  logic [SLOTS-1:0] block_ff;

  initial begin
    if (SLOTS < 2) $error("slots too small");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_ff <= '0;
      block_ff <= '0;
    end else begin
      if (set_valid) begin
        valid_ff[idx] <= 1'b1;
        block_ff[idx] <= 1'b0;
      end
      if (set_block) begin
        block_ff[idx] <= 1'b1;
      end
    end
  end

  assign valid   = valid_ff[idx];
  assign blocked = block_ff[idx];
endmodule : epcc_slot

//--- core/epcc_top.sv
// Purpose: operand checks and flags for page create and block leaves
// Assumes: apb slave, single clock, memory side modelled by env bits
// Notes: one command per go pulse; result in status after two cycles
`timescale 1ns/10ps
module epcc_top #(
  parameter int SLOTS = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        conflict_busy,
  output logic             done,
  output epcc_pkg::epcc_fault_type fault
);
  import epcc_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CHECK = 2'b01,
    ST_DONE  = 2'b10
  } epcc_state_type;

  localparam int IW = $clog2(SLOTS);

  epcc_state_type state_ff;
  epcc_state_type nxt_state;
  logic [7:0]  leaf_ff;
  logic [63:0] param_ff;
  logic [63:0] targ_ff;
  logic [31:0] src_ff;
  logic [31:0] sinfo_ff;
  logic [63:0] size_ff;
  logic [63:0] base_ff;
  logic [31:0] attr_ff;
  logic [31:0] ssa_ff;
  logic [5:0]  env_ff;
  logic [31:0] need_ff;
  logic        busy_ff;
  logic        zf_ff;
  logic        cf_ff;
  logic        flags_clr_ff;
  logic        done_ff;
  epcc_fault_type fault_ff;
  logic [31:0] code_ff;

  wire         wr_en;
  wire         rd_en;
  wire         go;
  wire         is_create;
  wire         is_block;
  wire         slot_valid;
  wire         slot_blocked;
  wire [IW-1:0] slot_idx;
  wire         in_cache;
  wire         misalign;
  wire         noncanon;
  wire         size_bad;
  wire         ssa_bad;
  wire         extended_feature_mask_bad;
  wire         field_bad;
  wire         gp_create;
  wire         pf_create;
  wire         gp_block;
  wire         pf_block;
  epcc_fault_type nxt_fault;
  wire         nxt_zf;
  wire         nxt_cf;
  wire         do_create;
  wire         do_block;

  function automatic logic canon(input logic [63:0] a);
    canon = (a[63:VA_BITS-1] == '0) || (a[63:VA_BITS-1] == '1);
  endfunction : canon

  function automatic logic pow2(input logic [63:0] v);
    pow2 = (v != 64'h0) && ((v & (v - 64'h1)) == 64'h0);
  endfunction : pow2

  initial begin
    if (SLOTS < 2) $error("slots too small");
  end

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign go    = wr_en && (paddr == ADDR_CTRL) && pwdata[CTRL_GO]
                 && (state_ff == ST_IDLE);
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  assign is_create = (leaf_ff == LEAF_CREATE);
  assign is_block  = (leaf_ff == LEAF_BLOCK);
  assign slot_idx  = targ_ff[PAGE_BITS +: IW];
  assign in_cache  = (targ_ff[63:PAGE_BITS+IW] == '0);

  // alignment of descriptor, target, source and security info
  assign misalign = (is_create && param_ff[DESC_BITS-1:0] != '0)
                  || (targ_ff[PAGE_BITS-1:0] != '0)
                  || (is_create && src_ff[PAGE_BITS-1:0] != '0)
                  || (is_create && sinfo_ff[SINFO_BITS-1:0] != '0);
  assign noncanon = env_ff[ENV_M64]
                    && (!canon(param_ff) || !canon(targ_ff));
  assign size_bad = (size_ff < MIN_SIZE) || !pow2(size_ff)
                    || ((base_ff & (size_ff - 64'h1)) != 64'h0);
  assign ssa_bad  = ({ssa_ff, 12'h000} < {12'h000, need_ff});
  assign extended_feature_mask_bad = (attr_ff[1:0] & EXTENDED_FEATURE_MASK_LOW) != EXTENDED_FEATURE_MASK_LOW;
  assign field_bad = !env_ff[ENV_DESC_ZERO] || !env_ff[ENV_SINFO_OK]
                     || !env_ff[ENV_RSV_ZERO];

  assign gp_create = misalign || noncanon || field_bad
                   || (!env_ff[ENV_M64] && env_ff[ENV_LIMIT])
                   || conflict_busy
                   || extended_feature_mask_bad || ssa_bad || size_bad;
  assign pf_create = !in_cache || slot_valid
                   || env_ff[ENV_ACC_FAULT];
  assign gp_block  = misalign || noncanon
                   || (!env_ff[ENV_M64] && env_ff[ENV_LIMIT]);
  assign pf_block  = !in_cache || env_ff[ENV_ACC_FAULT];

  assign nxt_fault = is_create ? (gp_create ? FLT_GP :
                                  pf_create ? FLT_PF : FLT_NONE) :
                     is_block  ? (gp_block ? FLT_GP :
                                  pf_block ? FLT_PF : FLT_NONE) :
                     FLT_GP;
  assign nxt_zf = conflict_busy || !slot_valid;
  assign nxt_cf = !nxt_zf && slot_blocked;
  assign do_create = (state_ff == ST_CHECK) && is_create
                     && (nxt_fault == FLT_NONE);
  assign do_block  = (state_ff == ST_CHECK) && is_block
                     && (nxt_fault == FLT_NONE) && !nxt_zf && !nxt_cf;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:  if (go) nxt_state = ST_CHECK;
      ST_CHECK: nxt_state = ST_DONE;
      ST_DONE:  nxt_state = ST_IDLE;
      default:  nxt_state = ST_IDLE;
    endcase
  end

  epcc_slot #(
    .SLOTS     (SLOTS)
  ) u_slot (
    .pclk      (pclk),
    .presetn   (presetn),
    .idx       (slot_idx),
    .set_valid (do_create),
    .set_block (do_block),
    .valid     (slot_valid),
    .blocked   (slot_blocked)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      leaf_ff  <= 8'h00;
      param_ff <= 64'h0;
      targ_ff  <= 64'h0;
      src_ff   <= 32'h0;
      sinfo_ff <= 32'h0;
      size_ff  <= 64'h0;
      base_ff  <= 64'h0;
      attr_ff  <= 32'h0;
      ssa_ff   <= 32'h0;
      env_ff   <= 6'h00;
      need_ff  <= 32'h0;
    end else if (wr_en && state_ff == ST_IDLE) begin
      unique case (paddr)
        ADDR_LEAF:     leaf_ff          <= pwdata[7:0];
        ADDR_PARAM_LO: param_ff[31:0]   <= pwdata;
        ADDR_PARAM_HI: param_ff[63:32]  <= pwdata;
        ADDR_TARG_LO:  targ_ff[31:0]    <= pwdata;
        ADDR_TARG_HI:  targ_ff[63:32]   <= pwdata;
        ADDR_SRC_LO:   src_ff           <= pwdata;
        ADDR_SINFO_LO: sinfo_ff         <= pwdata;
        ADDR_SIZE_LO:  size_ff[31:0]    <= pwdata;
        ADDR_SIZE_HI:  size_ff[63:32]   <= pwdata;
        ADDR_BASE_LO:  base_ff[31:0]    <= pwdata;
        ADDR_BASE_HI:  base_ff[63:32]   <= pwdata;
        ADDR_ATTR:     attr_ff          <= pwdata;
        ADDR_SSA:      ssa_ff           <= pwdata;
        ADDR_ENV:      env_ff           <= pwdata[5:0];
        ADDR_NEED:     need_ff          <= pwdata;
        default:       ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff     <= ST_IDLE;
      busy_ff      <= 1'b0;
      done_ff      <= 1'b0;
      fault_ff     <= FLT_NONE;
      code_ff      <= 32'h0;
      zf_ff        <= 1'b0;
      cf_ff        <= 1'b0;
      flags_clr_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      done_ff  <= (state_ff == ST_CHECK);
      if (go) begin
        busy_ff <= 1'b1;
      end else if (state_ff == ST_DONE) begin
        busy_ff <= 1'b0;
      end
      if (state_ff == ST_CHECK) begin
        fault_ff <= nxt_fault;
        code_ff  <= GP_CODE;
        if (is_block && nxt_fault == FLT_NONE) begin
          zf_ff        <= nxt_zf;
          cf_ff        <= nxt_cf;
          flags_clr_ff <= 1'b1;
        end else begin
          zf_ff        <= 1'b0;
          cf_ff        <= 1'b0;
          flags_clr_ff <= 1'b0;
        end
      end
    end
  end

  // status: [0]busy [1]done [3:2]fault [4]zf [5]cf [6]pf/af/of/sf cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ADDR_LEAF:   prdata <= {24'h0, leaf_ff};
        ADDR_STATUS: prdata <= {25'h0, flags_clr_ff, cf_ff, zf_ff,
                                fault_ff, done_ff, busy_ff};
        ADDR_ATTR:   prdata <= attr_ff;
        ADDR_SSA:    prdata <= ssa_ff;
        ADDR_NEED:   prdata <= need_ff;
        default:     prdata <= 32'h0;
      endcase
    end
  end

  assign done  = done_ff;
  assign fault = fault_ff;

  property p_extended_feature_mask;
    @(posedge pclk) disable iff (!presetn)
      (state_ff == ST_CHECK && is_create && extended_feature_mask_bad) |=> fault_ff == FLT_GP;
  endproperty
  a_extended_feature_mask: assert property (p_extended_feature_mask) else $error("extended_feature_mask not faulted");

  property p_size;
    @(posedge pclk) disable iff (!presetn)
      (state_ff == ST_CHECK && is_create && size_ff < MIN_SIZE)
      |=> fault_ff == FLT_GP;
  endproperty
  a_size: assert property (p_size) else $error("small size ok");

  property p_valid;
    @(posedge pclk) disable iff (!presetn)
      do_create |=> slot_valid;
  endproperty
  a_valid: assert property (p_valid) else $error("slot not valid");

  property p_revalid;
    @(posedge pclk) disable iff (!presetn)
      (state_ff == ST_CHECK && is_create && slot_valid && !gp_create)
      |=> fault_ff == FLT_PF;
  endproperty
  a_revalid: assert property (p_revalid) else $error("reuse no pf");

  property p_busy;
    @(posedge pclk) disable iff (!presetn)
      (state_ff == ST_CHECK && conflict_busy && is_create)
      |=> fault_ff == FLT_GP;
  endproperty
  a_busy: assert property (p_busy) else $error("busy no gp");

  sequence s_go;
    go ##1 state_ff == ST_CHECK;
  endsequence
  property p_done;
    @(posedge pclk) disable iff (!presetn)
      s_go |=> done_ff ##1 !done_ff;
  endproperty
  a_done: assert property (p_done) else $error("done timing");

  property p_zf;
    @(posedge pclk) disable iff (!presetn)
      (state_ff == ST_CHECK && is_block && nxt_fault == FLT_NONE
       && !slot_valid) |=> zf_ff && !cf_ff;
  endproperty
  a_zf: assert property (p_zf) else $error("zf wrong");

  property p_cf;
    @(posedge pclk) disable iff (!presetn)
      (state_ff == ST_CHECK && is_block && nxt_fault == FLT_NONE
       && slot_valid && !conflict_busy && slot_blocked) |=> cf_ff;
  endproperty
  a_cf: assert property (p_cf) else $error("cf wrong");

  property p_align;
    @(posedge pclk) disable iff (!presetn)
      (state_ff == ST_CHECK && targ_ff[PAGE_BITS-1:0] != '0)
      |=> fault_ff == FLT_GP;
  endproperty
  a_align: assert property (p_align) else $error("misalign ok");
endmodule : epcc_top

//--- verif/testbench.sv
// Purpose: self-checking bench for the page create/block checker
// Assumes: zero-wait apb slave, status polled after each go
// Notes: reference model keeps per-slot valid bits
`timescale 1ns/10ps
module testbench;
  import epcc_pkg::*;
  logic        pclk          = 1'b0;
  logic        presetn       = 1'b0;
  logic        psel          = 1'b0;
  logic        penable       = 1'b0;
  logic        pwrite        = 1'b0;
  logic [7:0]  paddr         = 8'h00;
  logic [31:0] pwdata        = 32'h0;
  logic        conflict_busy = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        done;
  epcc_fault_type fault;
  integer      seed          = 2978;
  int          errors        = 0;
  int          num_checks    = 0;
  logic [7:0]  leaf;
  logic [63:0] par;
  logic [63:0] targ;
  logic [63:0] size;
  logic [63:0] base;
  logic [31:0] src;
  logic [31:0] sinf;
  logic [31:0] attr;
  logic [31:0] ssa;
  logic [31:0] need;
  logic [5:0]  env;
  logic        cb;
  logic        vld [16];
  logic        blk [16];

  epcc_top u_epcc_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conflict_busy(conflict_busy),
    .done(done), .fault(fault)
  );

  always #10 pclk = ~pclk;

  task end_sim();
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  task check(input string nm, input logic [63:0] seen,
             input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      end_sim();
    end
    q = prdata;
    check("pslverr", pslverr, 64'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task apb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : apb_wr

  task setup(input int slot);
    leaf = LEAF_CREATE;
    par = 64'h2_0040;
    targ = 64'(slot) << PAGE_BITS;
    src = 32'h3_0000;
    sinf = 32'h4_0040;
    size = MIN_SIZE;
    base = 64'h0;
    attr = 32'h3;
    ssa = 32'h10;
    need = 32'h1000;
    env = 6'b00_1111;
    cb = 1'b0;
  endtask : setup

  task cmd();
    logic [31:0] q;
    logic        gp;
    logic        pf;
    logic [1:0]  ef;
    logic        ezf;
    logic        ecf;
    int          n;
    apb_wr(ADDR_LEAF, {24'h0, leaf});
    apb_wr(ADDR_PARAM_LO, par[31:0]);
    apb_wr(ADDR_PARAM_HI, par[63:32]);
    apb_wr(ADDR_TARG_LO, targ[31:0]);
    apb_wr(ADDR_TARG_HI, targ[63:32]);
    apb_wr(ADDR_SRC_LO, src);
    apb_wr(ADDR_SINFO_LO, sinf);
    apb_wr(ADDR_SIZE_LO, size[31:0]);
    apb_wr(ADDR_SIZE_HI, size[63:32]);
    apb_wr(ADDR_BASE_LO, base[31:0]);
    apb_wr(ADDR_BASE_HI, base[63:32]);
    apb_wr(ADDR_ATTR, attr);
    apb_wr(ADDR_SSA, ssa);
    apb_wr(ADDR_NEED, need);
    apb_wr(ADDR_ENV, {26'h0, env});
    conflict_busy <= cb;
    apb_wr(ADDR_CTRL, 32'h1);
    gp = env[0] && ((par[63:47] != 17'h0 && par[63:47] != 17'h1ffff)
         || (targ[63:47] != 17'h0 && targ[63:47] != 17'h1ffff));
    gp = gp || (!env[0] && env[5]);
    pf = env[4] || targ >= 64'h1_0000;
    ezf = cb || !vld[targ[15:12]];
    ecf = !ezf && blk[targ[15:12]];
    if (leaf == LEAF_CREATE) begin
      gp = gp || par[4:0] != 0 || targ[11:0] != 0 || src[11:0] != 0;
      gp = gp || sinf[5:0] != 0 || !env[1] || !env[2] || !env[3];
      gp = gp || cb || attr[1:0] != EXTENDED_FEATURE_MASK_LOW;
      gp = gp || 64'(ssa) * 64'h1000 < 64'(need);
      gp = gp || size < MIN_SIZE || (size & (size - 1)) != 0;
      gp = gp || (base & (size - 1)) != 0;
      pf = pf || vld[targ[15:12]];
    end else if (leaf == LEAF_BLOCK) begin
      gp = gp || targ[11:0] != 0;
    end else begin
      gp = 1'b1;
    end
    ef = gp ? FLT_GP : (pf ? FLT_PF : FLT_NONE);
    if (ef == FLT_NONE && leaf == LEAF_CREATE) begin
      vld[targ[15:12]] = 1'b1;
      blk[targ[15:12]] = 1'b0;
    end
    if (ef == FLT_NONE && leaf == LEAF_BLOCK && !ezf)
      blk[targ[15:12]] = 1'b1;
    #1;
    check("done", done, 64'h1);
    check("fault", fault, ef);
    @(posedge pclk);
    #1;
    check("done_end", done, 64'h0);
    @(posedge pclk);
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0, q);
      n++;
    end while (q[0] !== 1'b0 && n < 20);
    if (n >= 20) begin
      errors++;
      end_sim();
    end
    check("status_fault", q[3:2], ef);
    if (leaf == LEAF_BLOCK && ef == FLT_NONE) begin
      check("zero_flag", q[4], ezf);
      check("carry_flag", q[5], ecf);
      check("other_flags", q[6], 64'h1);
    end
  endtask : cmd

  initial begin
    logic [31:0] q;
    for (int i = 0; i < 16; i++) begin
      vld[i] = 1'b0;
      blk[i] = 1'b0;
    end
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h80, 32'h0, q);
    check("unmapped", q, 64'h0);
    apb_wr(8'h80, $random(seed));
    apb(1'b0, 8'h80, 32'h0, q);
    check("unmapped_wr", q, 64'h0);
    for (int k = 0; k < 26; k++) begin
      setup((k == 1) ? 1 : (k % 14) + 1);
      case (k)
        2: targ = 64'h1_0000;
        3: targ = targ + 64'h8;
        4: par = par + 64'h10;
        5: sinf = sinf + ({$random(seed)} % 63) + 1;
        6: src = src + 32'h800;
        7: env[1] = 1'b0;
        8: env[3] = 1'b0;
        9: env[2] = 1'b0;
        10: env[4] = 1'b1;
        11: env = 6'b10_1110;
        12: par[63:32] = 32'h0001_0000;
        13: cb = 1'b1;
        14: attr = 32'h1;
        15: size = 64'h1000;
        16: size = 64'h6000;
        17: base = 64'h1000;
        18: ssa = 32'h0;
        19: env[4] = 1'b1;
        20: leaf = 8'h05;
        21: env[0] = 1'b0;
        default: leaf = LEAF_BLOCK;
      endcase
      case (k)
        19: targ = targ + 64'h40;
        22: targ = 64'h1000;
        23: targ = 64'h1000;
        24: targ = 64'h3000;
        25: targ = 64'h2_0000;
        default: ;
      endcase
      cmd();
    end
    for (int i = 0; i < 6; i++) begin
      setup(10 + i);
      size = MIN_SIZE << ({$random(seed)} % 8);
      base = size * ({$random(seed)} % 4);
      need = 32'h1000 + ({$random(seed)} % 32'h8000);
      cmd();
      leaf = LEAF_BLOCK;
      cb = 1'b1;
      cmd();
      cb = 1'b0;
      cmd();
      cmd();
    end
    end_sim();
  end
endmodule : testbench
